// ===== rtl/arm_macrocell.sv
// One output macrocell: product terms, polarity stage, flip-flop and bypass.
`timescale 1ns/1ns
`include "arm_consts.svh"

module arm_macrocell
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Configuration write port
    input  wire logic        wrEn,
    input  wire logic [4:0]  wrWord,
    input  wire logic [31:0] wrData,
    input  wire logic [31:0] wrMask,
    // Configuration read port
    input  wire logic [4:0]  rdWord,
    output logic      [31:0] rdData,
    // Array literals
    input  wire logic [29:0] literals,
    // Cell results
    output logic             cellOut,
    output logic             oeTerm
);

    logic [29:0]        trueMask_r [`ARM_NTERM];
    logic [29:0]        compMask_r [`ARM_NTERM];
    arm_pkg::arm_cfg_t  cfg_r;
    logic               q_r;
    logic               qNxt;
    logic               clkTermPrev_r;
    logic [7:0]         termVal;
    logic               anyTerm;
    logic               dIn;
    logic               clkRise;
    logic               rstTerm;
    logic               preTerm;
    logic               preloadHit;
    logic               termHit;
    logic [4:0]         termOff;
    logic [2:0]         termIdx;
    logic               termComp;

    // An empty term is false, so an unused clock, reset or preset term never fires.
    for (genvar t = 0; t < `ARM_NTERM; t++)
    begin : gTerm
        assign termVal[t] = (|(trueMask_r[t] | compMask_r[t]))
                          & (&(~trueMask_r[t] | literals))
                          & (&(~compMask_r[t] | ~literals));
    end

    assign anyTerm    = |termVal[`ARM_NDTERM-1:0];                       // [R2]
    assign dIn        = ~(anyTerm ^ cfg_r.polarity);                      // [R7] [R10]
    assign clkRise    = termVal[`ARM_T_CLK] & ~clkTermPrev_r;             // [R6]
    assign rstTerm    = termVal[`ARM_T_RST];
    assign preTerm    = termVal[`ARM_T_PRE];
    assign oeTerm     = termVal[`ARM_T_OE];
    assign preloadHit = wrEn && (wrWord == `ARM_W_STATE) && wrMask[0];
    assign termOff    = wrWord - `ARM_W_TERM0;
    assign termIdx    = termOff[3:1];
    assign termComp   = termOff[0];
    assign termHit    = wrEn && (wrWord >= `ARM_W_TERM0) && (wrWord <= `ARM_W_TERMN);
    assign cellOut    = cfg_r.bypass ? dIn : q_r;                         // [R4]

    // Reset and preset win over preload and the clock term, and ignore the polarity bit.
    assign qNxt = rstTerm    ? 1'b0 :                                     // [R1] [R8]
                  preTerm    ? 1'b1 :                                     // [R8]
                  preloadHit ? wrData[0] :                                // [R8]
                  clkRise    ? dIn : q_r;                                 // [R5]

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            q_r           <= 1'b0;
            clkTermPrev_r <= 1'b0;
        end
        else
        begin
            q_r           <= qNxt;
            clkTermPrev_r <= termVal[`ARM_T_CLK];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cfg_r <= '0;
            for (int t = 0; t < `ARM_NTERM; t++)
            begin
                trueMask_r[t] <= '0;
                compMask_r[t] <= '0;
            end
        end
        else
        begin
            if (wrEn && (wrWord == `ARM_W_CTRL) && wrMask[0])
            begin
                cfg_r.polarity <= wrData[`ARM_CTRL_POL];
                cfg_r.bypass   <= wrData[`ARM_CTRL_BYP];
            end
            if (termHit && termComp)
                compMask_r[termIdx] <= (compMask_r[termIdx] & ~wrMask[29:0]) | (wrData[29:0] & wrMask[29:0]);
            if (termHit && !termComp)
                trueMask_r[termIdx] <= (trueMask_r[termIdx] & ~wrMask[29:0]) | (wrData[29:0] & wrMask[29:0]);
        end
    end

    logic [4:0] rdOff;
    assign rdOff = rdWord - `ARM_W_TERM0;

    always_comb
    begin
        rdData = '0;
        if (rdWord == `ARM_W_CTRL)
            rdData[1:0] = cfg_r;
        else if (rdWord == `ARM_W_STATE)
            rdData[0] = q_r;
        else if ((rdWord >= `ARM_W_TERM0) && (rdWord <= `ARM_W_TERMN))
            rdData[29:0] = rdOff[0] ? compMask_r[rdOff[3:1]] : trueMask_r[rdOff[3:1]];
    end

    a_clock_capture: assert property (@(posedge ref_clk) disable iff (srst) // [R5]
        clkRise && !rstTerm && !preTerm && !preloadHit |=> q_r == $past(dIn))
        else $error("Flip-flop missed data on clock term edge.");

    a_no_edge_hold: assert property (@(posedge ref_clk) disable iff (srst) // [R5]
        !clkRise && !rstTerm && !preTerm && !preloadHit |=> $stable(q_r))
        else $error("Flip-flop changed without a clock term edge.");

    a_reset_force: assert property (@(posedge ref_clk) disable iff (srst) // [R8]
        rstTerm |=> !q_r)
        else $error("Reset term did not clear the flip-flop.");

    a_preset_force: assert property (@(posedge ref_clk) disable iff (srst) // [R8]
        preTerm && !rstTerm |=> q_r)
        else $error("Preset term did not set the flip-flop.");

    a_polarity_high: assert property (@(posedge ref_clk) disable iff (srst) // [R7]
        anyTerm |-> dIn == cfg_r.polarity)
        else $error("Data input does not follow the polarity bit.");

    a_polarity_low: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
        !anyTerm |-> dIn != cfg_r.polarity)
        else $error("Data input not inverted with no term true.");

    a_bypass_select: assert property (@(posedge ref_clk) disable iff (srst) // [R4]
        cfg_r.bypass && clkRise && !rstTerm && !preTerm && !preloadHit |=> q_r == $past(cellOut))
        else $error("Bypassed cell and its flip-flop disagree.");

endmodule

// ===== rtl/arm_top.sv
// Ten-macrocell asynchronous register array with a Wishbone configuration slave.
`timescale 1ns/1ns
`include "arm_consts.svh"

// Overview of operation
// R1: Ten flip-flops, own reset, preset, clock terms.
// R2: Data input from four summed terms.
// R3: Tri-state outputs, term and shared pin.
// R4: Per-cell flip-flop bypass, freely mixed.
// R5: Capture only on own clock term edge.
// R6: Clock term is any input/feedback function.
// R7: Term true: data equals polarity bit.
// R8: Reset, preset, preload ignore polarity bit.
// R9: Ten dedicated inputs, ten macrocell I/O pins.
// R10: No term true: data inverts polarity.
// R11: Drive only when term and pin enable.
module arm_top
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Wishbone slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [31:0] wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatW,
    output logic      [31:0] wbDatR,
    output logic             wbAck,
    // Dedicated pins
    input  wire logic [9:0]  dedIn,
    input  wire logic        oePin_n,
    // I/O pins
    input  wire logic [9:0]  ioIn,
    output logic      [9:0]  ioOut,
    output logic      [9:0]  ioOe_n
);

    arm_pkg::arm_wb_req_t req;
    logic [9:0]  dedSync1_r;
    logic [9:0]  dedSync_r;
    logic [9:0]  ioSync1_r;
    logic [9:0]  ioSync_r;
    logic        oeSync1_r;
    logic        oeSync_r;
    logic [29:0] literals;
    logic [9:0]  cellOut;
    logic [9:0]  oeTerm;
    logic [31:0] cellRd [`ARM_NCELL];
    logic [31:0] wrMask;
    logic [3:0]  cellIdx;
    logic [4:0]  wordIdx;
    logic        mapped;
    logic        busHit;
    logic        wrHit;
    logic        ack_r;
    logic [31:0] datR_r;
    logic [31:0] datRNxt;
    logic [9:0]  ioOut_r;
    logic [9:0]  ioOe_n_r;
    logic [9:0]  ioOe_nNxt;

    assign req     = '{cyc: wbCyc, stb: wbStb, we: wbWe, adr: wbAdr, sel: wbSel, dat: wbDatW};
    assign cellIdx = req.adr[`ARM_ADR_CHI:`ARM_ADR_CLO];
    assign wordIdx = req.adr[`ARM_ADR_WHI:`ARM_ADR_WLO];
    assign mapped  = (req.adr[31:`ARM_ADR_TOPLO] == '0) && (cellIdx <= `ARM_CELL_LAST);
    // One wait state: the request is taken and answered on the same edge, ack falls next.
    assign busHit  = req.cyc && req.stb && !ack_r;
    // Writes land on the edge at which the master samples ack, while its request still stands.
    assign wrHit   = req.cyc && req.stb && req.we && ack_r;
    assign wrMask  = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};
    // Unmapped reads answer zero; unmapped writes are acknowledged and dropped.
    assign datRNxt = (busHit && !req.we) ? (mapped ? cellRd[cellIdx] : '0) : datR_r;

    // Feedback comes from the registered pin value, which keeps bypassed cells free of loops.
    assign literals  = {ioOut_r, ioSync_r, dedSync_r};                    // [R6] [R9]
    assign ioOe_nNxt = ~(oeTerm & {`ARM_NCELL{~oeSync_r}});               // [R3] [R11]

    for (genvar i = 0; i < `ARM_NCELL; i++)
    begin : gCell
        arm_macrocell uCell
        (
            .ref_clk  (ref_clk),
            .srst     (srst),
            .wrEn     (wrHit && mapped && (cellIdx == 4'(i))),
            .wrWord   (wordIdx),
            .wrData   (req.dat),
            .wrMask   (wrMask),
            .rdWord   (wordIdx),
            .rdData   (cellRd[i]),
            .literals (literals),
            .cellOut  (cellOut[i]),
            .oeTerm   (oeTerm[i])
        );
    end

    // Pins are asynchronous to ref_clk, so each passes two flip-flops first.
    always_ff @(posedge ref_clk)
    begin
        dedSync1_r <= dedIn;
        dedSync_r  <= dedSync1_r;
        ioSync1_r  <= ioIn;
        ioSync_r   <= ioSync1_r;
        oeSync1_r  <= oePin_n;
        oeSync_r   <= oeSync1_r;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ack_r    <= 1'b0;
            datR_r   <= '0;
            ioOut_r  <= '0;
            ioOe_n_r <= '1;
        end
        else
        begin
            ack_r    <= busHit;
            datR_r   <= datRNxt;
            ioOut_r  <= cellOut;                                           // [R9]
            ioOe_n_r <= ioOe_nNxt;                                         // [R3]
        end
    end

    assign wbAck  = ack_r;
    assign wbDatR = datR_r;
    assign ioOut  = ioOut_r;
    assign ioOe_n = ioOe_n_r;

    a_ack_single: assert property (@(posedge ref_clk) disable iff (srst)
        wbAck |=> !wbAck)
        else $error("Bus acknowledge lasted more than one cycle.");

    a_ack_timing: assert property (@(posedge ref_clk) disable iff (srst)
        wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("Bus request not acknowledged on the next edge.");

    a_pin_drive: assert property (@(posedge ref_clk) disable iff (srst) // [R11]
        ##1 ioOe_n == ~($past(oeTerm) & {`ARM_NCELL{!$past(oeSync_r)}}))
        else $error("Pin enable does not match term and enable pin.");

    a_pin_hiz: assert property (@(posedge ref_clk) disable iff (srst) // [R3]
        oeSync_r |=> ioOe_n == 10'h3ff)
        else $error("Pin driven while the shared enable pin is off.");

    a_pin_value: assert property (@(posedge ref_clk) disable iff (srst) // [R9]
        ##1 ioOut == $past(cellOut))
        else $error("Pin output does not follow its macrocell.");

endmodule

// ===== shared/arm_consts.svh
// Constants for the asynchronous-register macrocell array.
`ifndef ARM_CONSTS_SVH
`define ARM_CONSTS_SVH

`define ARM_NCELL      10
`define ARM_NIN        10
`define ARM_NLIT       30
`define ARM_NTERM      8
`define ARM_NDTERM     4
`define ARM_T_CLK      4
`define ARM_T_RST      5
`define ARM_T_PRE      6
`define ARM_T_OE       7
`define ARM_W_CTRL     5'h0
`define ARM_W_STATE    5'h1
`define ARM_W_TERM0    5'h2
`define ARM_W_TERMN    5'h11
`define ARM_CTRL_POL   0
`define ARM_CTRL_BYP   1
`define ARM_ADR_WLO    2
`define ARM_ADR_WHI    6
`define ARM_ADR_CLO    7
`define ARM_ADR_CHI    10
`define ARM_ADR_TOPLO  11
`define ARM_CELL_LAST  4'h9

`endif

// ===== shared/arm_pkg.sv
// Types shared by the macrocell array files.
package arm_pkg;

    typedef struct packed {
        logic        bypass;
        logic        polarity;
    } arm_cfg_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [31:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } arm_wb_req_t;

endpackage

// ===== verif/arm_pin_model.sv
// Board-side model of the dedicated pins, the shared enable pin and the ten I/O pins.
`timescale 1ns/1ns
module arm_pin_model
(
    // Clock
    input  wire logic       ref_clk,
    // Board levels chosen by the bench
    input  wire logic [9:0] dedSet,
    input  wire logic       oeSet_n,
    // Device side
    input  wire logic [9:0] ioOut,
    input  wire logic [9:0] ioOe_n,
    output logic      [9:0] dedIn,
    output logic            oePin_n,
    output logic      [9:0] ioIn
);
    logic [9:0] lastLvl_r = 10'h000;

    // The I/O lines have no pull, so a released line shows the inverse of its last driven level.
    always @(posedge ref_clk)
        for (int i = 0; i < 10; i++)
            if (ioOe_n[i] === 1'b0)
                lastLvl_r[i] <= ioOut[i];
    assign ioIn    = (~ioOe_n & ioOut) | (ioOe_n & ~lastLvl_r);
    assign dedIn   = dedSet;
    assign oePin_n = oeSet_n;
endmodule

// ===== verif/arm_top_tb.sv
// Self-checking bench for the macrocell array.
`timescale 1ns/1ns
module arm_top_tb;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, oePin_n;
    logic [31:0] wbAdr = '0, wbDatW = '0, wbDatR;
    logic [3:0]  wbSel = '0;
    logic        oeSet_n = 1'b0, pinReq = 1'b0;
    logic [9:0]  dedSet = '0, dedIn, ioIn, ioOut, ioOe_n, pol = '0, byp = '0, q = '0;
    logic [31:0] expQ[$];
    string       nameQ[$];
    int          n_mismatch = 0, samples_checked = 0;

    always #10 ref_clk = ~ref_clk;

    arm_top i_arm_top (.ref_clk(ref_clk), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .dedIn(dedIn),
        .oePin_n(oePin_n), .ioIn(ioIn), .ioOut(ioOut), .ioOe_n(ioOe_n));
    arm_pin_model i_arm_pin_model (.ref_clk(ref_clk), .dedSet(dedSet), .oeSet_n(oeSet_n), .ioOut(ioOut),
        .ioOe_n(ioOe_n), .dedIn(dedIn), .oePin_n(oePin_n), .ioIn(ioIn));

    task automatic results();
        $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Oldest note is matched against each read answer or pin sample.
    always @(posedge ref_clk)
        if ((wbAck === 1'b1 && wbWe === 1'b0) || pinReq)
        begin
            check(nameQ.pop_front(), pinReq ? {12'h000, ioOe_n, ioOut} : wbDatR, expQ.pop_front());
            pinReq <= 1'b0;
        end

    function automatic logic [31:0] cad(int i, logic [31:0] off);
        return 32'(i) * 32'h0000_0080 + off;
    endfunction

    function automatic logic [9:0] dv();
        return dedSet[0] ? pol : ~pol;
    endfunction

    task automatic wb(logic we, logic [31:0] adr, logic [31:0] dat);
        @(posedge ref_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hF;
        wbDatW <= dat;
        do @(posedge ref_clk); while (wbAck !== 1'b1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic rd(string what, logic [31:0] adr, logic [31:0] exp);
        expQ.push_back(exp);
        nameQ.push_back(what);
        wb(1'b0, adr, 32'h0000_0000);
    endtask

    task automatic pins(string what, logic [9:0] oeN);
        repeat (6) @(posedge ref_clk);
        expQ.push_back({12'h000, oeN, (byp & dv()) | (~byp & q)});
        nameQ.push_back(what);
        pinReq <= 1'b1;
        @(posedge ref_clk);
    endtask

    initial
    begin
        #(20 * 4000);
        n_mismatch++;
        results();
    end

    initial
    begin
        void'($urandom(33));
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        pins("pins after reset", 10'h3FF);
        rd("ctrl reset", cad(0, 32'h0000_0000), 32'h0000_0000);
        rd("state reset", cad(9, 32'h0000_0004), 32'h0000_0000);
        wb(1'b1, 32'h0000_0500, $urandom);
        rd("unmapped cell", 32'h0000_0500, 32'h0000_0000);
        rd("unmapped word", cad(3, 32'h0000_0048), 32'h0000_0000);
        wb(1'b1, cad(2, 32'h0000_0010), 32'hFFFF_FFFF);
        rd("mask width", cad(2, 32'h0000_0010), 32'h3FFF_FFFF);
        wb(1'b1, cad(2, 32'h0000_0010), 32'h0000_0000);
        wb(1'b1, cad(2, 32'h0000_0014), 32'hFFFF_FFFF);
        rd("comp mask width", cad(2, 32'h0000_0014), 32'h3FFF_FFFF);
        wb(1'b1, cad(2, 32'h0000_0014), 32'h0000_0000);
        $display("test registers done");
        pol = 10'($urandom);
        for (int i = 0; i < 10; i++)
        begin
            wb(1'b1, cad(i, 32'h0000_0008), 32'h0000_0001);
            wb(1'b1, cad(i, 32'h0000_0028), 32'h0000_0002);
            wb(1'b1, cad(i, 32'h0000_0030), 32'h0000_0008);
            wb(1'b1, cad(i, 32'h0000_0038), 32'h0000_0010);
            wb(1'b1, cad(i, 32'h0000_0040), 32'h0000_0004);
            wb(1'b1, cad(i, 32'h0000_0000), {31'h0, pol[i]});
            rd("ctrl", cad(i, 32'h0000_0000), {31'h0, pol[i]});
        end
        for (int k = 0; k < 4; k++)
        begin
            @(posedge ref_clk);
            dedSet[0] <= k[0];
            dedSet[2] <= 1'b1;
            repeat (4) @(posedge ref_clk);
            dedSet[1] <= 1'b1;
            q = k[0] ? pol : ~pol;
            pins("capture", 10'h000);
            dedSet[0] <= ~k[0];
            pins("clock held high", 10'h000);
            dedSet[1] <= 1'b0;
        end
        $display("test capture done");
        oeSet_n <= 1'b1;
        pins("pin disabled", 10'h3FF);
        oeSet_n <= 1'b0;
        dedSet[2] <= 1'b0;
        pins("term disabled", 10'h3FF);
        dedSet[2] <= 1'b1;
        pins("enabled", 10'h000);
        $display("test enable done");
        dedSet[4] <= 1'b1;
        q = 10'h3FF;
        pins("preset", 10'h000);
        dedSet[3] <= 1'b1;
        q = 10'h000;
        pins("reset over preset", 10'h000);
        dedSet[4:3] <= 2'h0;
        wb(1'b1, cad(5, 32'h0000_0004), 32'h0000_0001);
        q[5] = 1'b1;
        rd("preload", cad(5, 32'h0000_0004), 32'h0000_0001);
        pins("preload pins", 10'h000);
        $display("test force done");
        byp = 10'h155;
        for (int i = 0; i < 10; i++)
            wb(1'b1, cad(i, 32'h0000_0000), {30'h0, byp[i], pol[i]});
        for (int k = 0; k < 2; k++)
        begin
            @(posedge ref_clk);
            dedSet[0] <= ~dedSet[0];
            pins("bypass mix", 10'h000);
        end
        $display("test bypass done");
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        byp = '0;
        q = '0;
        pins("pins after second reset", 10'h3FF);
        rd("ctrl after second reset", cad(4, 32'h0000_0000), 32'h0000_0000);
        rd("state after second reset", cad(5, 32'h0000_0004), 32'h0000_0000);
        $display("test second reset done");
        results();
    end
endmodule
